// ---- rac_pkg.sv ----
`default_nettype none
package rac_pkg;
    // register offsets on the serial register port
    localparam logic [3:0] ADDR_CTRL      = 4'hE;
    localparam logic [3:0] ADDR_STAT      = 4'hF;
    // interrupt_control fields
    localparam int         CTRL_WEEK_EN   = 7;
    localparam int         CTRL_DAY_EN    = 6;
    localparam int         CTRL_SEL_LSB   = 0;
    // interrupt_status fields
    localparam int         STAT_HALT      = 5;
    localparam int         STAT_PER       = 2;
    localparam int         STAT_WEEK      = 1;
    localparam int         STAT_DAY       = 0;
    // reset values: power-up from 0 V reports an oscillation halt
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] STAT_RESET     = 8'h20;
    // calendar values that mark period boundaries (bcd)
    localparam logic [7:0] BCD_ZERO       = 8'h00;
    localparam logic [7:0] BCD_FIRST_DAY  = 8'h01;
    // timing
    localparam int         CLK_PERIOD_NS  = 50;
    localparam int         SEC_NS         = 1_000_000_000;
    localparam int         SEC_CYC_DEF    = SEC_NS / CLK_PERIOD_NS;
    localparam int         INC_DELAY_US   = 92;
    localparam int         INC_DELAY_CYC  = INC_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int         ADJ_MAX_US     = 3784;
    localparam int         ADJ_MAX_CYC    = ADJ_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int         ADJ_EVERY_SEC  = 20;
    localparam int         CNT_W          = 26;
    localparam int         ADJ_W          = 18;
    // periodic select encodings
    typedef enum logic [2:0] {
        PER_OFF   = 3'b000,
        PER_LOW   = 3'b001,
        PER_2HZ   = 3'b010,
        PER_1HZ   = 3'b011,
        PER_SEC   = 3'b100,
        PER_MIN   = 3'b101,
        PER_HOUR  = 3'b110,
        PER_MONTH = 3'b111
    } rac_per_mode_t;
endpackage : rac_pkg
`default_nettype wire

// ---- rac_alarm_cmp.sv ----
`timescale 1ns/1ps
`default_nettype none
module rac_alarm_cmp
    import rac_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // comparison inputs
    input  wire logic       enable,
    input  wire logic       wday_ok,
    input  wire logic [7:0] cur_hour,
    input  wire logic [7:0] cur_min,
    input  wire logic [7:0] alm_hour,
    input  wire logic [7:0] alm_min,
    // result
    output logic            set_pulse
);
    logic match;
    logic match_q;

    assign match = wday_ok && (cur_hour == alm_hour) && (cur_min == alm_min);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match;
        end
    end

    // only the start of a match counts, so arming during a match waits for the next one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            set_pulse <= 1'b0;
        end else begin
            set_pulse <= enable && match && !match_q; // see RQ6 see RQ9
        end
    end
endmodule : rac_alarm_cmp
`default_nettype wire

// ---- rac_timebase.sv ----
`timescale 1ns/1ps
`default_nettype none
module rac_timebase
    import rac_pkg::*;
#(
    parameter int unsigned SEC_CYC = SEC_CYC_DEF
)(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // control
    input  wire logic              restart,
    input  wire logic              adj_en,
    input  wire logic signed [ADJ_W-1:0] adj_cycles,
    // timing outputs
    output logic                   sec_inc,
    output logic                   p1_low,
    output logic                   p2_low
);
    localparam logic [CNT_W-1:0] SEC_LEN  = CNT_W'(SEC_CYC);
    localparam logic [CNT_W-1:0] HALF_LEN = CNT_W'(SEC_CYC / 2);
    localparam logic [CNT_W-1:0] QTR_LEN  = CNT_W'(SEC_CYC / 4);
    localparam logic [CNT_W-1:0] INC_AT   = CNT_W'(INC_DELAY_CYC);
    localparam logic signed [ADJ_W-1:0] ADJ_HI = ADJ_W'(ADJ_MAX_CYC);
    localparam logic signed [ADJ_W-1:0] ADJ_LO = ADJ_W'(-ADJ_MAX_CYC);
    localparam logic [4:0] ADJ_LAST = 5'(ADJ_EVERY_SEC - 1);

    logic [CNT_W-1:0]       cnt;
    logic [CNT_W-1:0]       next_cnt;
    logic [4:0]             sec_mod;
    logic signed [ADJ_W-1:0] adj_clamp;
    logic [CNT_W-1:0]       adj_now;
    logic [CNT_W-1:0]       len;
    logic [CNT_W-1:0]       half;
    logic                   wrap;

    // one second in twenty is stretched or shrunk by the clamped amount
    always_comb begin
        adj_clamp = adj_cycles;
        if (adj_cycles > ADJ_HI) begin
            adj_clamp = ADJ_HI;
        end else if (adj_cycles < ADJ_LO) begin
            adj_clamp = ADJ_LO;
        end
        adj_now = (adj_en && sec_mod == 5'h00) ? CNT_W'(adj_clamp) : '0; // see RQ18
        len     = SEC_LEN + adj_now;
        half    = HALF_LEN + adj_now;
        wrap    = (cnt == len - 1'b1);
        if (restart) begin
            next_cnt = '0; // see RQ17
        end else if (wrap) begin
            next_cnt = '0;
        end else begin
            next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt     <= '0;
            sec_mod <= '0;
        end else begin
            cnt <= next_cnt;
            if (restart) begin
                sec_mod <= '0;
            end else if (wrap) begin
                sec_mod <= (sec_mod == ADJ_LAST) ? 5'h00 : sec_mod + 5'h01;
            end
        end
    end

    // falling edge at count zero, second increment a fixed delay later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_inc <= 1'b0;
            p1_low  <= 1'b0;
            p2_low  <= 1'b0;
        end else begin
            sec_inc <= !restart && (next_cnt == INC_AT); // see RQ16
            p1_low  <= next_cnt < half; // see RQ15
            p2_low  <= (next_cnt < QTR_LEN + adj_now) ||
                       (next_cnt >= half && next_cnt < half + QTR_LEN);
        end
    end
endmodule : rac_timebase
`default_nettype wire

// ---- rac_irq_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1: alarm time match drives interrupt low
// RQ2: status flags at bits two, one, zero
// RQ3: enables at bits seven, six, selects low
// RQ4: reset defaults keep interrupt released high
// RQ5: any active source pulls output low
// RQ6: alarm enable gates its comparator
// RQ7: writing zero clears flag, one ignored
// RQ8: flag clear leaves enable armed
// RQ9: enabling during match waits next match
// RQ10: host disables, loads, then enables alarm
// RQ11: select codes off, low, 2Hz, 1Hz
// RQ12: level codes second, minute, hour, month
// RQ13: level event at each period boundary
// RQ14: level output holds until flag cleared
// RQ15: pulse falling edges align with seconds
// RQ16: second increments 92 us after fall
// RQ17: second write restarts divider, output low
// RQ18: adjustment alters one second in twenty
// RQ19: flags record which source interrupted
// RQ20: output is open-drain pull-down enable
// RQ21: oscillation halt clears enables and flags
module rac_irq_top
    import rac_pkg::*;
#(
    parameter int unsigned SEC_CYC = SEC_CYC_DEF
)(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    output logic      [7:0]        reg_rdata,
    // time counters
    input  wire logic [2:0]        cur_wday,
    input  wire logic [7:0]        cur_hour,
    input  wire logic [7:0]        cur_min,
    input  wire logic [7:0]        cur_sec,
    input  wire logic [7:0]        cur_mday,
    input  wire logic              sec_write,
    output logic                   sec_inc,
    // alarm settings
    input  wire logic [6:0]        alm_w_wday,
    input  wire logic [7:0]        alm_w_hour,
    input  wire logic [7:0]        alm_w_min,
    input  wire logic [7:0]        alm_d_hour,
    input  wire logic [7:0]        alm_d_min,
    // oscillator status and adjustment
    input  wire logic              osc_halt_det,
    input  wire logic              adj_en,
    input  wire logic signed [ADJ_W-1:0] adj_cycles,
    // interrupt pin
    output logic                   irq_out_n,
    output logic                   irq_oe
);
    logic          rst_meta_n;
    logic          rst_sync_n;
    logic          week_alarm_enable;
    logic          day_alarm_enable;
    rac_per_mode_t per_mode;
    logic          week_alarm_flag;
    logic          day_alarm_flag;
    logic          periodic_flag;
    logic          osc_halt_flag;
    logic          wr_ctrl;
    logic          wr_stat;
    logic          week_set;
    logic          day_set;
    logic          p1_low;
    logic          p2_low;
    logic          sec_inc_q;
    logic          level_mode;
    logic          lvl_evt;
    logic          per_set;
    logic          per_low;
    logic          next_irq_low;

    // reset release through two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
    assign wr_stat = reg_wr && (reg_addr == ADDR_STAT);

    // interrupt_control
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            week_alarm_enable <= CTRL_RESET[CTRL_WEEK_EN]; // see RQ4
            day_alarm_enable  <= CTRL_RESET[CTRL_DAY_EN];
            per_mode          <= rac_per_mode_t'(CTRL_RESET[CTRL_SEL_LSB +: 3]);
        end else if (osc_halt_det) begin
            week_alarm_enable <= 1'b0; // see RQ21
            day_alarm_enable  <= 1'b0;
            per_mode          <= PER_OFF;
        end else if (wr_ctrl) begin
            week_alarm_enable <= reg_wdata[CTRL_WEEK_EN]; // see RQ3
            day_alarm_enable  <= reg_wdata[CTRL_DAY_EN];
            per_mode          <= rac_per_mode_t'(reg_wdata[CTRL_SEL_LSB +: 3]);
        end
    end

    rac_alarm_cmp u_week_cmp (
        .clk       (core_clk),
        .rst_n     (rst_sync_n),
        .enable    (week_alarm_enable),
        .wday_ok   (alm_w_wday[cur_wday]),
        .cur_hour  (cur_hour),
        .cur_min   (cur_min),
        .alm_hour  (alm_w_hour),
        .alm_min   (alm_w_min),
        .set_pulse (week_set)
    );

    rac_alarm_cmp u_day_cmp (
        .clk       (core_clk),
        .rst_n     (rst_sync_n),
        .enable    (day_alarm_enable),
        .wday_ok   (1'b1),
        .cur_hour  (cur_hour),
        .cur_min   (cur_min),
        .alm_hour  (alm_d_hour),
        .alm_min   (alm_d_min),
        .set_pulse (day_set)
    );

    rac_timebase #(
        .SEC_CYC (SEC_CYC)
    ) u_timebase (
        .clk        (core_clk),
        .rst_n      (rst_sync_n),
        .restart    (sec_write),
        .adj_en     (adj_en),
        .adj_cycles (adj_cycles),
        .sec_inc    (sec_inc),
        .p1_low     (p1_low),
        .p2_low     (p2_low)
    );

    // counters show the new second one cycle after the increment
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sec_inc_q <= 1'b0;
        end else begin
            sec_inc_q <= sec_inc;
        end
    end

    assign level_mode = per_mode[2];

    always_comb begin
        case (per_mode)
            PER_SEC:   lvl_evt = sec_inc_q; // see RQ12 see RQ13
            PER_MIN:   lvl_evt = sec_inc_q && cur_sec == BCD_ZERO;
            PER_HOUR:  lvl_evt = sec_inc_q && cur_sec == BCD_ZERO && cur_min == BCD_ZERO;
            PER_MONTH: lvl_evt = sec_inc_q && cur_sec == BCD_ZERO && cur_min == BCD_ZERO &&
                                 cur_hour == BCD_ZERO && cur_mday == BCD_FIRST_DAY;
            default:   lvl_evt = 1'b0;
        endcase
    end

    always_comb begin
        case (per_mode)
            PER_OFF: per_low = 1'b0; // see RQ11
            PER_LOW: per_low = 1'b1;
            PER_2HZ: per_low = p2_low;
            PER_1HZ: per_low = p1_low;
            default: per_low = periodic_flag; // see RQ14
        endcase
    end

    assign per_set = level_mode ? lvl_evt : per_low;

    // interrupt_status flags: a set in the same cycle as a clear wins
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            week_alarm_flag <= STAT_RESET[STAT_WEEK];
            day_alarm_flag  <= STAT_RESET[STAT_DAY];
            periodic_flag   <= STAT_RESET[STAT_PER];
        end else if (osc_halt_det) begin
            week_alarm_flag <= 1'b0; // see RQ21
            day_alarm_flag  <= 1'b0;
            periodic_flag   <= 1'b0;
        end else begin
            week_alarm_flag <= week_set || (week_alarm_flag && !(wr_stat && !reg_wdata[STAT_WEEK])); // see RQ7 see RQ19
            day_alarm_flag  <= day_set || (day_alarm_flag && !(wr_stat && !reg_wdata[STAT_DAY]));
            periodic_flag   <= per_set || (periodic_flag && !(wr_stat && !reg_wdata[STAT_PER]));
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            osc_halt_flag <= STAT_RESET[STAT_HALT];
        end else begin
            osc_halt_flag <= osc_halt_det || (osc_halt_flag && !(wr_stat && !reg_wdata[STAT_HALT]));
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                ADDR_CTRL: reg_rdata <= {week_alarm_enable, day_alarm_enable, 3'b000, per_mode}; // see RQ3
                ADDR_STAT: reg_rdata <= {2'b00, osc_halt_flag, 2'b00,
                                         periodic_flag, week_alarm_flag, day_alarm_flag}; // see RQ2
                default:   reg_rdata <= 8'h00;
            endcase
        end
    end

    // wired-or of all asserted sources onto one pull-down
    assign next_irq_low = (week_alarm_flag && week_alarm_enable) || // see RQ1 see RQ5 see RQ8
                          (day_alarm_flag && day_alarm_enable) || per_low;

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_out_n <= 1'b1;
            irq_oe    <= 1'b0;
        end else begin
            irq_out_n <= !next_irq_low; // see RQ20
            irq_oe    <= next_irq_low;
        end
    end

    a_pin_pair: assert property (@(posedge core_clk) disable iff (!rst_sync_n) // see RQ20
        irq_oe == !irq_out_n) else $error("pull-down enable and level disagree");
    a_week_alarm_irq: assert property (@(posedge core_clk) disable iff (!rst_sync_n) // see RQ1
        week_set && !osc_halt_det ##1 week_alarm_enable |=> !irq_out_n) else $error("weekly alarm did not pull low");
    a_flag_clear_wr: assert property (@(posedge core_clk) disable iff (!rst_sync_n) // see RQ7
        wr_stat && !reg_wdata[STAT_DAY] && !day_set |=> !day_alarm_flag) else $error("day flag not cleared");
    a_flag_write_one: assert property (@(posedge core_clk) disable iff (!rst_sync_n) // see RQ7
        wr_stat && reg_wdata[STAT_WEEK] && week_alarm_flag && !osc_halt_det |=> week_alarm_flag)
        else $error("writing one disturbed week flag");
    a_clear_keeps_en: assert property (@(posedge core_clk) disable iff (!rst_sync_n) // see RQ8
        wr_stat && !wr_ctrl && !osc_halt_det |=> $stable(week_alarm_enable) && $stable(day_alarm_enable))
        else $error("status write touched enables");
    a_idle_high: assert property (@(posedge core_clk) disable iff (!rst_sync_n) // see RQ4
        per_mode == PER_OFF && !week_alarm_enable && !day_alarm_enable |=> irq_out_n)
        else $error("interrupt low while all sources disabled");
    a_level_hold: assert property (@(posedge core_clk) disable iff (!rst_sync_n) // see RQ14
        level_mode && periodic_flag && !wr_stat && !osc_halt_det && !wr_ctrl |=> ##1 !irq_out_n)
        else $error("level interrupt released without clear");
    a_fixed_low: assert property (@(posedge core_clk) disable iff (!rst_sync_n) // see RQ11
        per_mode == PER_LOW && !wr_ctrl && !osc_halt_det |=> ##1 !irq_out_n) else $error("fixed low not driven");
    a_halt_clears: assert property (@(posedge core_clk) disable iff (!rst_sync_n) // see RQ21
        osc_halt_det |=> per_mode == PER_OFF && !week_alarm_enable && !day_alarm_flag && osc_halt_flag)
        else $error("halt did not clear interrupt state");
    a_sec_restart_low: assert property (@(posedge core_clk) disable iff (!rst_sync_n) // see RQ17
        sec_write && per_mode == PER_1HZ && !wr_ctrl && !osc_halt_det |=> ##1 !irq_out_n)
        else $error("second write did not drive output low");

    c_week_alarm: cover property (@(posedge core_clk) disable iff (!rst_sync_n) week_set ##2 !irq_out_n);
    c_level_clear: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
        periodic_flag && level_mode && wr_stat && !reg_wdata[STAT_PER]);
    c_pulse_edge: cover property (@(posedge core_clk) disable iff (!rst_sync_n) per_mode == PER_2HZ && $rose(p2_low));
endmodule : rac_irq_top
`default_nettype wire

// ---- rac_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rac_host_model (
    // clock
    input  wire logic       core_clk,
    // register port
    output logic      [3:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    input  wire logic [7:0] reg_rdata,
    // interrupt pin
    input  wire logic       irq_oe,
    output logic            irq_line
);
    // board pull-up: the pin is low only while the device pulls it down
    assign irq_line = irq_oe ? 1'b0 : 1'b1;

    initial begin
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
    end

    task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr    = 1'b0;
    endtask : write_reg

    // reading the flags tells the host which source pulled the pin
    task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        repeat (3) @(negedge core_clk);
        d = reg_rdata;
    endtask : read_reg
endmodule : rac_host_model
`default_nettype wire

// ---- rtc_alarm_periodic_irq_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_periodic_irq_test
    import rac_pkg::*;
;
    localparam int unsigned SEC   = 4000;
    localparam int          LIMIT = 60000;
    logic                    core_clk, rst_n, reg_wr, sec_write, sec_inc;
    logic              [3:0] reg_addr;
    logic              [7:0] reg_wdata, reg_rdata, cur_hour, cur_min, cur_sec, cur_mday;
    logic              [2:0] cur_wday;
    logic              [6:0] alm_w_wday;
    logic              [7:0] alm_w_hour, alm_w_min, alm_d_hour, alm_d_min, v, m, hr;
    logic                    osc_halt_det, adj_en, irq_out_n, irq_oe, irq_line;
    logic signed [ADJ_W-1:0] adj_cycles;
    int                      fails, n_checks;

    rac_irq_top #(.SEC_CYC(SEC)) i_rac_irq_top (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rdata(reg_rdata), .cur_wday(cur_wday), .cur_hour(cur_hour),
        .cur_min(cur_min), .cur_sec(cur_sec), .cur_mday(cur_mday), .sec_write(sec_write),
        .sec_inc(sec_inc), .alm_w_wday(alm_w_wday), .alm_w_hour(alm_w_hour), .alm_w_min(alm_w_min),
        .alm_d_hour(alm_d_hour), .alm_d_min(alm_d_min), .osc_halt_det(osc_halt_det),
        .adj_en(adj_en), .adj_cycles(adj_cycles), .irq_out_n(irq_out_n), .irq_oe(irq_oe));
    rac_host_model i_rac_host_model (
        .core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rdata(reg_rdata), .irq_oe(irq_oe), .irq_line(irq_line));

    always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

    // second counter model: steps when the block asks for it
    always @(negedge core_clk) begin
        if (sec_inc === 1'b1) begin
            cur_sec <= bcd_inc(cur_sec);
        end
    end

    function automatic logic [7:0] bcd_inc(input logic [7:0] s);
        if (s == 8'h59) return 8'h00;
        if (s[3:0] == 4'h9) return {s[7:4] + 4'h1, 4'h0};
        return s + 8'h01;
    endfunction : bcd_inc

    function automatic logic [7:0] to_bcd(input int x);
        return {4'(x / 10), 4'(x % 10)};
    endfunction : to_bcd

    // level event expected once the second counter reaches s
    function automatic logic lvl_fire(input logic [2:0] md, input logic [7:0] s, mi, h, d);
        case (md)
            3'b100:  return 1'b1;
            3'b101:  return s == 8'h00;
            3'b110:  return s == 8'h00 && mi == 8'h00;
            default: return s == 8'h00 && mi == 8'h00 && h == 8'h00 && d == 8'h01;
        endcase
    endfunction : lvl_fire

    function automatic logic near(input int a, input int b, input int tol);
        return a >= b - tol && a <= b + tol;
    endfunction : near

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t ns: %s saw %0h expected %0h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_rac_host_model.write_reg(a, d);
    endtask : wr

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string msg);
        logic [7:0] d;
        i_rac_host_model.read_reg(a, d);
        check(d, e, msg);
    endtask : rd_chk

    task automatic cycles(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cycles

    task automatic pulse_sec_write;
        @(negedge core_clk);
        sec_write = 1'b1;
        @(negedge core_clk);
        sec_write = 1'b0;
    endtask : pulse_sec_write

    task automatic wait_sec(output int n);
        n = 0;
        while (sec_inc !== 1'b1 && n < SEC + 50) begin
            @(negedge core_clk);
            n++;
        end
    endtask : wait_sec

    // move the minute away and back so a fresh match begins
    task automatic rematch(input logic [7:0] mm);
        @(negedge core_clk);
        cur_min = bcd_inc(mm);
        cycles(2);
        cur_min = mm;
        cycles(4);
    endtask : rematch

    task automatic run_level(input logic [2:0] md, input logic [7:0] h, mi, d, s0);
        int   n;
        logic e;
        pulse_sec_write();
        cur_hour = h;
        cur_min  = mi;
        cur_mday = d;
        cur_sec  = s0;
        wr(ADDR_CTRL, {5'h00, md});
        wr(ADDR_STAT, 8'h00);
        wait_sec(n);
        check(n < SEC, 1'b1, "second increment seen");
        e = lvl_fire(md, bcd_inc(s0), mi, h, d);
        cycles(3);
        check(irq_line, !e, "level assert");
        rd_chk(ADDR_STAT, {5'h00, e, 2'b00}, "level flag");
        cycles(20);
        check(irq_line, !e, "level hold");
        wr(ADDR_STAT, 8'hfb);
        cycles(3);
        check(irq_line, 1'b1, "level release");
    endtask : run_level

    task automatic run_pulse(input logic [2:0] c, input int half, input int adj);
        int t;
        int rise;
        int fall;
        int inc;
        adj_en     = adj != 0;
        adj_cycles = ADJ_W'(adj);
        wr(ADDR_CTRL, {5'h00, c});
        pulse_sec_write();
        cycles(2);
        check(irq_line, 1'b0, "restart low");
        t    = 2;
        rise = 0;
        fall = 0;
        inc  = 0;
        while (fall == 0 && t < 2 * SEC) begin
            @(negedge core_clk);
            t++;
            if (inc == 0 && sec_inc === 1'b1) inc = t;
            if (rise == 0 && irq_line === 1'b1) rise = t;
            if (rise != 0 && fall == 0 && irq_line === 1'b0) fall = t;
        end
        check(near(rise, half + adj, 4), 1'b1, "low time");
        check(near(fall, 2 * half + adj, 4), 1'b1, "pulse period");
        check(near(inc, INC_DELAY_CYC, 4), 1'b1, "increment delay");
    endtask : run_pulse

    initial begin
        repeat (LIMIT) @(posedge core_clk);
        fails++;
        complete_run();
    end

    initial begin
        core_clk     = 1'b0;
        rst_n        = 1'b0;
        sec_write    = 1'b0;
        osc_halt_det = 1'b0;
        adj_en       = 1'b0;
        adj_cycles   = '0;
        cur_wday     = 3'h3;
        cur_hour     = 8'h10;
        cur_min      = 8'h20;
        cur_sec      = 8'h00;
        cur_mday     = 8'h15;
        alm_w_wday   = 7'h00;
        alm_w_hour   = 8'h23;
        alm_w_min    = 8'h59;
        alm_d_hour   = 8'h23;
        alm_d_min    = 8'h59;
        fails        = 0;
        n_checks     = 0;
        void'($urandom(32'h28c1));
        repeat (8) @(posedge core_clk);
        check(irq_oe, 1'b0, "pin during reset");
        @(negedge core_clk);
        rst_n = 1'b1;
        cycles(4);
        rd_chk(ADDR_CTRL, CTRL_RESET, "control reset");
        rd_chk(ADDR_STAT, STAT_RESET, "status reset");
        check(irq_line, 1'b1, "idle pin");
        wr(4'h3, 8'hff);
        rd_chk(4'h3, 8'h00, "unmapped read");
        rd_chk(ADDR_CTRL, 8'h00, "unmapped write ignored");
        repeat (4) begin
            v = 8'($urandom);
            wr(ADDR_CTRL, v);
            rd_chk(ADDR_CTRL, v & 8'hc7, "control fields");
        end
        wr(ADDR_CTRL, 8'h01);
        cycles(3);
        check(irq_line, 1'b0, "fixed low");
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_STAT, 8'h00);
        cycles(3);
        check(irq_line, 1'b1, "periodic off");
        m  = to_bcd($urandom_range(0, 58));
        hr = to_bcd($urandom_range(0, 23));
        cur_hour   = hr;
        cur_min    = m;
        // disable, load alarm time equal to now, then enable
        wr(ADDR_CTRL, 8'h00);
        alm_d_hour = hr;
        alm_d_min  = m;
        alm_w_hour = hr;
        alm_w_min  = m;
        alm_w_wday = 7'h08;
        wr(ADDR_CTRL, 8'h40);
        cycles(10);
        check(irq_line, 1'b1, "no early alarm");
        rd_chk(ADDR_STAT, 8'h00, "no early flag");
        rematch(m);
        check(irq_line, 1'b0, "daily alarm");
        check(irq_oe, 1'b1, "pull-down on");
        check(irq_out_n, 1'b0, "interrupt level");
        rd_chk(ADDR_STAT, 8'h01, "daily flag");
        wr(ADDR_STAT, 8'hfe);
        rd_chk(ADDR_STAT, 8'h00, "flag cleared");
        check(irq_line, 1'b1, "alarm released");
        rd_chk(ADDR_CTRL, 8'h40, "enable kept");
        wr(ADDR_CTRL, 8'hc0);
        rematch(m);
        rd_chk(ADDR_STAT, 8'h03, "both flags");
        wr(ADDR_STAT, 8'hfd);
        rd_chk(ADDR_STAT, 8'h01, "weekly cleared");
        check(irq_line, 1'b0, "other source holds");
        wr(ADDR_STAT, 8'hfe);
        wr(ADDR_CTRL, 8'h80);
        rematch(m);
        rd_chk(ADDR_STAT, 8'h02, "enable gates daily");
        wr(ADDR_STAT, 8'h00);
        cycles(3);
        check(irq_line, 1'b1, "all cleared");
        run_level(3'b100, 8'h12, 8'h34, 8'h15, 8'h27);
        run_level(3'b101, 8'h12, 8'h34, 8'h15, 8'h59);
        run_level(3'b101, 8'h12, 8'h34, 8'h15, 8'h30);
        run_level(3'b110, 8'h00, 8'h00, 8'h15, 8'h59);
        run_level(3'b111, 8'h00, 8'h00, 8'h02, 8'h59);
        run_level(3'b111, 8'h00, 8'h00, 8'h01, 8'h59);
        run_pulse(3'b011, SEC / 2, 0);
        run_pulse(3'b011, SEC / 2, $urandom_range(1, 400));
        run_pulse(3'b010, SEC / 4, 0);
        wr(ADDR_CTRL, 8'hc1);
        @(negedge core_clk);
        osc_halt_det = 1'b1;
        @(negedge core_clk);
        osc_halt_det = 1'b0;
        rd_chk(ADDR_CTRL, 8'h00, "halt clears control");
        rd_chk(ADDR_STAT, 8'h20, "halt clears flags");
        check(irq_line, 1'b1, "halt releases pin");
        complete_run();
    end
endmodule : rtc_alarm_periodic_irq_test
`default_nettype wire
